// ---- design/rx_irq_pkg.sv ----
// package for the receive interrupt enable block: register map, field layouts,
// reset values and error-state thresholds.
// assumes a 32-bit classic wishbone slave with byte addresses; data in low byte.
package rx_irq_pkg;

  // register bus geometry
  localparam int ADR_W = 4;                       // byte address width of the slave
  localparam int DAT_W = 32;                      // wishbone data width
  localparam int CNT_W = 9;                       // error counter width, reaches past 255

  // register offsets, byte addresses
  localparam logic [3:0] FLAG_OFS = 4'h0;         // receive_flag_register
  localparam logic [3:0] ENABLE_OFS = 4'h4;       // receive_interrupt_enables
  localparam logic [3:0] CONTROL_OFS = 4'h8;      // control_register_zero

  // bit positions shared by flags and enables
  localparam int WAKE_BIT = 7;                    // wake flag / wake_irq_enable
  localparam int STATE_CHANGE_BIT = 6;            // state change flag / enable
  localparam int OVERRUN_BIT = 1;                 // overrun flag / enable
  localparam int RX_FULL_BIT = 0;                 // rx full flag / enable

  // control register bit positions
  localparam int INIT_REQ_BIT = 0;                // init_request, read/write
  localparam int INIT_ACK_BIT = 1;                // init_acknowledge, read only
  localparam int WAKE_FUNC_BIT = 2;               // wake_function_enable

  // reset values
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [1:0] STATE_RESET = 2'h0;

  // bits of the enable register cleared by initialization mode
  localparam logic [7:0] INIT_CLEAR_MASK = 8'hC3;
  // sticky event bits of the flag register
  localparam logic [7:0] EVENT_MASK = 8'hC3;

  // error counter thresholds
  localparam logic [CNT_W-1:0] WARN_LIMIT = 9'h060;    // 96
  localparam logic [CNT_W-1:0] PASSIVE_LIMIT = 9'h07F; // 127
  localparam logic [CNT_W-1:0] BUSOFF_LIMIT = 9'h0FF;  // 255

  // error state codes
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'h0,                             // error active
    ST_WARNING = 2'h1,                            // warning level
    ST_PASSIVE = 2'h2,                            // error passive
    ST_BUSOFF = 2'h3                              // bus-off
  } err_state_t;

  // sensitivity codes
  localparam logic [1:0] SENS_NONE = 2'h0;
  localparam logic [1:0] SENS_BUSOFF = 2'h1;
  localparam logic [1:0] SENS_PASSIVE = 2'h2;
  localparam logic [1:0] SENS_ALL = 2'h3;

  // layout of receive_interrupt_enables
  typedef struct packed {
    logic wake_irq_enable;
    logic state_change_irq_enable;
    logic [1:0] rx_state_sensitivity;
    logic [1:0] tx_state_sensitivity;
    logic overrun_irq_enable;
    logic rx_full_irq_enable;
  } enables_t;

  // layout of receive_flag_register
  typedef struct packed {
    logic wake_flag;
    logic state_change_flag;
    logic [1:0] rx_state_bits;
    logic [1:0] tx_state_bits;
    logic overrun_flag;
    logic rx_full_flag;
  } flags_t;

endpackage : rx_irq_pkg

// ---- design/err_state_tracker.sv ----
// error state tracker: turns an error count into a state code, holds the
// reported code while a status change is pending, and flags qualifying changes.
// assumes counts are synchronous to clk; bus_off is decided by the caller.
`timescale 1ns/100ps
`default_nettype none
module err_state_tracker #(
  parameter int CNT_W = rx_irq_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [CNT_W-1:0] err_count,
  input wire logic bus_off,
  input wire logic [1:0] sensitivity,
  input wire logic hold,
  output logic [1:0] state_reg,
  output logic change_hit
);

  // count to state code, shared by the receiver and transmitter side
  function automatic logic [1:0] state_code(input logic [CNT_W-1:0] cnt, input logic off);
    if (off) begin
      state_code = rx_irq_pkg::ST_BUSOFF;
    end else if (cnt > rx_irq_pkg::PASSIVE_LIMIT) begin
      state_code = rx_irq_pkg::ST_PASSIVE;
    end else if (cnt > rx_irq_pkg::WARN_LIMIT) begin
      state_code = rx_irq_pkg::ST_WARNING;
    end else begin
      state_code = rx_irq_pkg::ST_ACTIVE;
    end
  endfunction : state_code

  logic [1:0] actual;                             // live state from the counters
  logic moved;                                    // live state differs from reported, no change pending
  logic qualifies;                                // change passes the sensitivity filter

  // sensitivity filter on the move from state_reg to actual
  always_comb begin
    actual = state_code(err_count, bus_off);
    moved = (actual != state_reg) && !hold;
    case (sensitivity)
      rx_irq_pkg::SENS_BUSOFF: qualifies = (actual == rx_irq_pkg::ST_BUSOFF) ||
                                           (state_reg == rx_irq_pkg::ST_BUSOFF);
      rx_irq_pkg::SENS_PASSIVE: qualifies = actual[1] || state_reg[1];
      rx_irq_pkg::SENS_ALL: qualifies = 1'b1;
      default: qualifies = 1'b0;
    endcase
    change_hit = moved && qualifies;
  end

  // reported state follows the live one only while nothing is pending
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= rx_irq_pkg::STATE_RESET;
    end else if (ce && moved) begin
      state_reg <= actual;
    end
  end

endmodule : err_state_tracker
`default_nettype wire

// ---- design/can_rx_interrupt_enable.sv ----
// receive interrupt enable block: enable register, sticky receive flags,
// error state reporting and the interrupt request outputs.
// assumes a classic wishbone master on clk and event pulses synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module can_rx_interrupt_enable #(
  parameter int CNT_W = rx_irq_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rx_irq_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [rx_irq_pkg::DAT_W-1:0] wb_dat_i,
  output logic [rx_irq_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic wake_activity,
  input wire logic overrun_event,
  input wire logic rx_full_event,
  input wire logic [CNT_W-1:0] rx_error_count,
  input wire logic [CNT_W-1:0] tx_error_count,
  output logic wake_irq,
  output logic error_irq,
  output logic rx_irq,
  output logic irq
);

  // bus slave states, gray along idle -> ack -> idle
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK = 2'h1
  } bus_state_t;

  bus_state_t bus_reg;                            // slave handshake state
  bus_state_t bus_next;
  rx_irq_pkg::enables_t enables_reg;              // receive_interrupt_enables
  rx_irq_pkg::flags_t flags;                      // flag register as read
  logic [7:0] event_flags_reg;                    // sticky event bits, layout of flags
  logic init_request_reg;                         // software init request
  logic init_acknowledge_reg;                     // follows the request one cycle later
  logic wake_function_reg;                        // wake_function_enable
  logic [7:0] rd_data_reg;                        // captured read byte
  logic [rx_irq_pkg::ADR_W-1:0] adr_q;            // whole address compared by decode, low bits included
  logic req;                                      // new request seen in idle
  logic wr_commit;                                // write takes effect this edge
  logic rd_commit;                                // flag register read completes this edge
  logic init_mode;                                // both init bits high
  logic writable;                                 // both init bits low
  logic [1:0] rx_state;                           // reported receiver state
  logic [1:0] tx_state;                           // reported transmitter state
  logic rx_hit;                                   // qualifying receiver change
  logic tx_hit;                                   // qualifying transmitter change
  logic bus_off;                                  // transmit counter past 255
  logic [7:0] set_mask;                           // event bits set this cycle
  logic [7:0] clr_mask;                           // event bits cleared by a read
  logic [7:0] enable_wr;                          // enable write value, low byte of wb_dat_i unmasked

  assign adr_q = wb_adr_i;

  // handshake: answer one cycle after the request, for one cycle
  // ack does not look at stb again, so a master must not abort mid-cycle
  always_comb begin
    req = wb_cyc_i && wb_stb_i && (bus_reg == BUS_IDLE);
    case (bus_reg)
      BUS_IDLE: bus_next = req ? BUS_ACK : BUS_IDLE;
      BUS_ACK: bus_next = BUS_IDLE;
      default: bus_next = BUS_IDLE;
    endcase
    wr_commit = (bus_reg == BUS_ACK) && wb_we_i && wb_sel_i[0];
    rd_commit = (bus_reg == BUS_ACK) && !wb_we_i && (adr_q == rx_irq_pkg::FLAG_OFS);
    wb_ack_o = (bus_reg == BUS_ACK);
    wb_dat_o = {24'h000000, rd_data_reg};
  end

  // slave state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_reg <= BUS_IDLE;
    end else if (ce) begin
      bus_reg <= bus_next;
    end
  end

  // flag register view: sticky events plus reported states
  always_comb begin
    flags = rx_irq_pkg::flags_t'(event_flags_reg);
    flags.rx_state_bits = rx_state;
    flags.tx_state_bits = tx_state;
  end

  // read byte captured at request time; decode by address
  // capturing early keeps dat_o steady for the whole ack cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_reg <= 8'h00;
    end else if (ce && req) begin
      if (adr_q == rx_irq_pkg::FLAG_OFS) begin
        rd_data_reg <= flags;
      end else if (adr_q == rx_irq_pkg::ENABLE_OFS) begin
        rd_data_reg <= enables_reg;
      end else if (adr_q == rx_irq_pkg::CONTROL_OFS) begin
        rd_data_reg <= {5'h00, wake_function_reg, init_acknowledge_reg, init_request_reg};
      end else begin
        rd_data_reg <= 8'h00;                            // unmapped reads as zero
      end
    end
  end

  // control register: init request, its acknowledge, wake function
  // software leaves init mode by clearing the request; the acknowledge follows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_request_reg <= 1'b0;
      init_acknowledge_reg <= 1'b0;
      wake_function_reg <= 1'b0;
    end else if (ce) begin
      // acknowledge trails the request so the two pass through mixed states
      init_acknowledge_reg <= init_request_reg;
      if (wr_commit && (adr_q == rx_irq_pkg::CONTROL_OFS)) begin
        init_request_reg <= wb_dat_i[rx_irq_pkg::INIT_REQ_BIT];
        wake_function_reg <= wb_dat_i[rx_irq_pkg::WAKE_FUNC_BIT];
      end
    end
  end

  assign init_mode = init_request_reg && init_acknowledge_reg;
  assign writable = !init_request_reg && !init_acknowledge_reg;
  assign enable_wr = wb_dat_i[7:0];

  // enable register: gated writes, init mode clears all but sensitivity
  // writes in the mixed init states are dropped, not deferred
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enables_reg <= rx_irq_pkg::ENABLE_RESET;
    end else if (ce) begin
      if (init_mode) begin
        // sensitivity fields keep their programmed values
        enables_reg <= enables_reg & ~rx_irq_pkg::INIT_CLEAR_MASK;
      end else if (wr_commit && writable && (adr_q == rx_irq_pkg::ENABLE_OFS)) begin
        enables_reg <= enable_wr;
      end
    end
  end

  // error state trackers, both frozen while a status change is pending
  // bus-off comes from the transmit count alone and drives both codes,
  // so a transmitter leaving bus-off drags the receiver back as well
  assign bus_off = tx_error_count > rx_irq_pkg::BUSOFF_LIMIT;

  err_state_tracker #(.CNT_W(CNT_W)) rx_track (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .err_count(rx_error_count),
    .bus_off(bus_off),
    .sensitivity(enables_reg.rx_state_sensitivity),
    .hold(event_flags_reg[rx_irq_pkg::STATE_CHANGE_BIT]),
    .state_reg(rx_state),
    .change_hit(rx_hit)
  );

  err_state_tracker #(.CNT_W(CNT_W)) tx_track (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .err_count(tx_error_count),
    .bus_off(bus_off),
    .sensitivity(enables_reg.tx_state_sensitivity),
    .hold(event_flags_reg[rx_irq_pkg::STATE_CHANGE_BIT]),
    .state_reg(tx_state),
    .change_hit(tx_hit)
  );

  // event set and read-clear masks; only bits the reader saw are cleared
  always_comb begin
    set_mask = 8'h00;
    // wake needs the wake function armed, software arms both enables
    set_mask[rx_irq_pkg::WAKE_BIT] = wake_activity && wake_function_reg;
    set_mask[rx_irq_pkg::STATE_CHANGE_BIT] = rx_hit || tx_hit;
    set_mask[rx_irq_pkg::OVERRUN_BIT] = overrun_event;
    set_mask[rx_irq_pkg::RX_FULL_BIT] = rx_full_event;
    clr_mask = rd_commit ? (rd_data_reg & rx_irq_pkg::EVENT_MASK) : 8'h00;
  end

  // sticky events: a set in the clearing cycle wins
  // the clear mask is the byte the reader saw, so a late event is not lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      event_flags_reg <= rx_irq_pkg::FLAG_RESET;
    end else if (ce) begin
      event_flags_reg <= (event_flags_reg & ~clr_mask) | set_mask;
    end
  end

  // request levels from registered flags and enables
  always_comb begin
    wake_irq = flags.wake_flag && enables_reg.wake_irq_enable;
    error_irq = (flags.state_change_flag && enables_reg.state_change_irq_enable) ||
                (flags.overrun_flag && enables_reg.overrun_irq_enable);
    rx_irq = flags.rx_full_flag && enables_reg.rx_full_irq_enable;
    irq = wake_irq || error_irq || rx_irq;
  end

  // checks on the block's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_timing_a: assert property (ce && req |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  enable_write_a: assert property (ce && wr_commit && writable && !init_mode &&
      adr_q == rx_irq_pkg::ENABLE_OFS |=> enables_reg == $past(enable_wr))
    else $error("enable write lost outside init mode");
  write_block_a: assert property (ce && !writable && !init_mode |=>
      $stable(enables_reg))
    else $error("enable register changed during init transition");
  init_force_a: assert property (ce && init_mode |=>
      (enables_reg & rx_irq_pkg::INIT_CLEAR_MASK) == 8'h00)
    else $error("enables not forced in init mode");
  sens_keep_a: assert property (init_mode |=>
      $stable(enables_reg[5:2]))
    else $error("sensitivity fields disturbed in init mode");
  wake_gate_a: assert property (wake_irq == (event_flags_reg[7] && enables_reg[7]))
    else $error("wake request does not follow flag and enable");
  error_gate_a: assert property (error_irq ==
      ((event_flags_reg[6] && enables_reg[6]) || (event_flags_reg[1] && enables_reg[1])))
    else $error("error request mismatch");
  rx_gate_a: assert property (ce && rx_full_event && enables_reg[0] ##1
      enables_reg[0] |-> rx_irq)
    else $error("receive full did not raise request");
  state_hold_a: assert property (event_flags_reg[6] |=>
      $stable(rx_state) && $stable(tx_state))
    else $error("state bits moved while change pending");
  busoff_code_a: assert property (ce && bus_off && !event_flags_reg[6] ##1 bus_off
      |-> tx_state == rx_irq_pkg::ST_BUSOFF && rx_state == rx_irq_pkg::ST_BUSOFF)
    else $error("bus-off not reported");
  set_wins_a: assert property (ce && overrun_event |=> event_flags_reg[1])
    else $error("overrun event lost");

  // an idle slave with no request stays silent
  ack_cause_a: assert property (ce && !req && !wb_ack_o |=> !wb_ack_o)
    else $error("ack without a request");
  // nothing moves while the clock enable is low
  freeze_hold_a: assert property (!ce |=> $stable(event_flags_reg) && $stable(enables_reg) &&
      $stable(bus_reg))
    else $error("state moved while clock enable low");
  // the wake flag arms only through the wake function enable
  wake_arm_a: assert property (ce && wake_activity && wake_function_reg |=>
      event_flags_reg[rx_irq_pkg::WAKE_BIT])
    else $error("armed wake activity did not set the wake flag");
  wake_block_a: assert property (ce && !wake_function_reg &&
      !event_flags_reg[rx_irq_pkg::WAKE_BIT] |=> !event_flags_reg[rx_irq_pkg::WAKE_BIT])
    else $error("wake flag set with the wake function off");
  // both sensitivities at 00 keep the change flag down
  sens_none_a: assert property (ce && enables_reg[5:2] == 4'h0 &&
      !event_flags_reg[rx_irq_pkg::STATE_CHANGE_BIT] |=>
      !event_flags_reg[rx_irq_pkg::STATE_CHANGE_BIT])
    else $error("change flag set with both sensitivities off");
  change_set_a: assert property (ce && (rx_hit || tx_hit) |=>
      event_flags_reg[rx_irq_pkg::STATE_CHANGE_BIT])
    else $error("qualifying state change did not set the flag");
  // a sticky flag stays until a read that saw it takes it away
  flag_keep_a: assert property (ce && !rd_commit &&
      event_flags_reg[rx_irq_pkg::RX_FULL_BIT] |=> event_flags_reg[rx_irq_pkg::RX_FULL_BIT])
    else $error("receive full flag lost without a read");
  read_clear_a: assert property (ce && rd_commit && !overrun_event &&
      rd_data_reg[rx_irq_pkg::OVERRUN_BIT] |=> !event_flags_reg[rx_irq_pkg::OVERRUN_BIT])
    else $error("overrun flag survived the read that saw it");
  // read data above the low byte is always zero
  dat_high_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data high bits not zero");
  // receiver bus-off never stands without transmitter bus-off
  rx_busoff_a: assert property (rx_state == rx_irq_pkg::ST_BUSOFF |->
      tx_state == rx_irq_pkg::ST_BUSOFF)
    else $error("receiver reports bus-off alone");

  // main scenarios the bench is expected to reach
  read_cov_c: cover property (req && !wb_we_i ##1 wb_ack_o);
  change_cov_c: cover property ($rose(event_flags_reg[6]) && enables_reg[6]);
  init_cov_c: cover property (init_mode ##1 !init_mode);
  wake_cov_c: cover property (ce && wake_activity && wake_function_reg);
  freeze_cov_c: cover property (!ce && overrun_event);

endmodule : can_rx_interrupt_enable
`default_nettype wire

// ---- tb/tb_can_rx_interrupt_enable.sv ----
// self-checking bench for the receive interrupt enable block: wishbone tasks,
// a reference model of enables, flags and error states, and the verdict.
// assumes the slave acks one cycle after it takes a request, ce high but for one freeze test.
`timescale 1ns/100ps
`default_nettype none
module tb_can_rx_interrupt_enable;
  logic clk, rst, ce; // clock, reset, clock enable (high but for one freeze test)
  logic wb_cyc_i, wb_stb_i, wb_we_i; // bus request
  logic [rx_irq_pkg::ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [rx_irq_pkg::DAT_W-1:0] wb_dat_i, wb_dat_o;
  logic wb_ack_o;
  logic wake_activity, overrun_event, rx_full_event; // event pulses
  logic [8:0] rx_error_count, tx_error_count;
  logic wake_irq, error_irq, rx_irq, irq;
  int err_count = 0; // mismatches seen
  int cmp_count = 0; // comparisons made
  logic [7:0] m_en, m_fl; // model enables and flags
  logic m_wfe; // model wake function enable
  logic [8:0] m_rx, m_tx; // model error counts
  int s, k, b;
  int src[3] = '{0, 1, 7}; // rx full, overrun, wake
  // count bands per step: rx band, tx band
  int bands[6][2] = '{'{1, 0}, '{2, 0}, '{0, 1}, '{0, 2}, '{0, 3}, '{0, 0}};

  can_rx_interrupt_enable dut (
    .clk(clk), .rst(rst), .ce(ce),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wake_activity(wake_activity), .overrun_event(overrun_event),
    .rx_full_event(rx_full_event), .rx_error_count(rx_error_count),
    .tx_error_count(tx_error_count), .wake_irq(wake_irq),
    .error_irq(error_irq), .rx_irq(rx_irq), .irq(irq)
  );

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // summary and verdict, the single end of the run
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // one comparison, four-state exact
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // error state code from counts; bus-off decided by the tx count alone
  function automatic logic [1:0] st(input logic [8:0] c, input logic [8:0] t);
    if (t > 9'h0FF) return 2'h3;
    if (c > 9'h07F) return 2'h2;
    if (c > 9'h060) return 2'h1;
    return 2'h0;
  endfunction : st

  // does a change from o to n qualify under sensitivity code sc
  function automatic logic qual(input logic [1:0] sc, input logic [1:0] o,
                                input logic [1:0] n);
    if (o == n) return 1'b0;
    return sc == 2'h3 || (sc == 2'h1 && (o == 2'h3 || n == 2'h3)) ||
           (sc == 2'h2 && (o >= 2'h2 || n >= 2'h2));
  endfunction : qual

  // random count inside a state band
  function automatic logic [8:0] band(input int bn);
    int lo[4] = '{0, 97, 128, 256};
    int sz[4] = '{97, 31, 128, 256};
    return 9'(lo[bn] + $urandom % sz[bn]);
  endfunction : band

  // model: state bits follow live state only while no change is pending
  task automatic track();
    logic [1:0] nr, nt;
    nr = st(m_rx, m_tx);
    nt = st(m_tx, m_tx);
    if (!m_fl[6]) begin
      if (qual(m_en[5:4], m_fl[5:4], nr) || qual(m_en[3:2], m_fl[3:2], nt)) begin
        m_fl[6] = 1'b1;
      end
      m_fl[5:4] = nr;
      m_fl[3:2] = nt;
    end
  endtask : track

  // classic single wishbone cycle; request held until ack is sampled
  task automatic bus(input logic we, input logic [3:0] adr, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      err_count++;
      $display("MISMATCH at %0t: bus answer missing", $time);
      complete_run();
    end
    if (!we) begin
      check(wb_dat_o, {24'h000000, d});
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : bus

  // read compare; a flag read clears the sticky event bits in the model
  task automatic rd_chk(input logic [3:0] adr, input logic [7:0] exp);
    bus(1'b0, adr, exp);
    if (adr == rx_irq_pkg::FLAG_OFS) begin
      m_fl = m_fl & 8'h3C;
      track();
    end
  endtask : rd_chk

  // request outputs against the model, after a few settling cycles
  task automatic check_irqs();
    logic w, e, r;
    w = m_fl[7] & m_en[7];
    e = (m_fl[6] & m_en[6]) | (m_fl[1] & m_en[1]);
    r = m_fl[0] & m_en[0];
    repeat (3) @(posedge clk);
    check({28'h0, wake_irq, error_irq, rx_irq, irq}, {28'h0, w, e, r, w | e | r});
  endtask : check_irqs

  // one-cycle event pulse; wake only counts with the wake function on
  task automatic pulse(input int bn);
    @(posedge clk);
    wake_activity <= (bn == 7);
    overrun_event <= (bn == 1);
    rx_full_event <= (bn == 0);
    @(posedge clk);
    wake_activity <= 1'b0;
    overrun_event <= 1'b0;
    rx_full_event <= 1'b0;
    if (bn != 7 || m_wfe) m_fl[bn] = 1'b1;
  endtask : pulse

  // new error counts, seen by the model at once
  task automatic counts(input logic [8:0] r, input logic [8:0] t);
    @(posedge clk);
    rx_error_count <= r;
    tx_error_count <= t;
    m_rx = r;
    m_tx = t;
    track();
  endtask : counts

  // main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {wake_activity, overrun_event, rx_full_event} = 3'h0;
    {rx_error_count, tx_error_count} = '0;
    {m_en, m_fl, m_wfe, m_rx, m_tx} = '0;
    void'($urandom(32'hFFA0));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // reset values, then an unmapped place
    rd_chk(rx_irq_pkg::ENABLE_OFS, 8'h00);
    rd_chk(rx_irq_pkg::FLAG_OFS, 8'h00);
    rd_chk(4'hC, 8'h00);
    // random enables written outside init and read back
    for (k = 0; k < 4; k++) begin
      m_en = 8'($urandom);
      bus(1'b1, rx_irq_pkg::ENABLE_OFS, m_en);
      rd_chk(rx_irq_pkg::ENABLE_OFS, m_en);
    end
    // event gating: wake function off, then masked, then enabled
    for (k = 0; k < 3; k++) begin
      m_wfe = (k > 0);
      bus(1'b1, rx_irq_pkg::CONTROL_OFS, {5'h00, m_wfe, 2'h0});
      m_en = (k == 2) ? 8'hC3 : 8'h00;
      bus(1'b1, rx_irq_pkg::ENABLE_OFS, m_en);
      for (b = 0; b < 3; b++) begin
        pulse(src[b]);
        check_irqs();
      end
      rd_chk(rx_irq_pkg::FLAG_OFS, m_fl);
      check_irqs();
    end
    // every sensitivity code on both sides over all state bands
    for (s = 0; s < 4; s++) begin
      m_en = {2'b01, 2'(s), 2'(s), 2'b00};
      bus(1'b1, rx_irq_pkg::ENABLE_OFS, m_en);
      for (k = 0; k < 6; k++) begin
        counts(band(bands[k][0]), band(bands[k][1]));
        check_irqs();
        rd_chk(rx_irq_pkg::FLAG_OFS, m_fl);
      end
    end
    // a pending change freezes the state bits until it is read away
    m_en = 8'h7C;
    bus(1'b1, rx_irq_pkg::ENABLE_OFS, m_en);
    counts(band(0), band(1));
    check_irqs();
    counts(band(0), band(2));
    check_irqs();
    rd_chk(rx_irq_pkg::FLAG_OFS, m_fl);
    check_irqs();
    rd_chk(rx_irq_pkg::FLAG_OFS, m_fl);
    // init mode clears the gates, keeps the sensitivities, refuses writes
    m_en = 8'hFF;
    bus(1'b1, rx_irq_pkg::ENABLE_OFS, m_en);
    bus(1'b1, rx_irq_pkg::CONTROL_OFS, 8'h01);
    m_wfe = 1'b0;
    repeat (3) @(posedge clk);
    m_en = m_en & 8'h3C;
    rd_chk(rx_irq_pkg::CONTROL_OFS, 8'h03);
    rd_chk(rx_irq_pkg::ENABLE_OFS, m_en);
    bus(1'b1, rx_irq_pkg::ENABLE_OFS, 8'h00);
    rd_chk(rx_irq_pkg::ENABLE_OFS, m_en);
    pulse(0);
    check_irqs();
    bus(1'b1, rx_irq_pkg::CONTROL_OFS, 8'h00);
    repeat (3) @(posedge clk);
    m_en = 8'hC3;
    bus(1'b1, rx_irq_pkg::ENABLE_OFS, m_en);
    rd_chk(rx_irq_pkg::ENABLE_OFS, m_en);
    check_irqs();
    // a frozen block ignores an overrun pulse
    @(posedge clk);
    ce <= 1'b0;
    overrun_event <= 1'b1;
    @(posedge clk);
    ce <= 1'b1;
    overrun_event <= 1'b0;
    rd_chk(rx_irq_pkg::FLAG_OFS, m_fl);
    check_irqs();
    complete_run();
  end
endmodule : tb_can_rx_interrupt_enable
`default_nettype wire
